//--- rtl/param_rom_pkg.sv
// package: offsets, field layouts and fixed contents of the parameter store
package param_rom_pkg;

    // ******************************************************************
    // bus register map (byte addresses, one aligned word each)
    // ******************************************************************
    localparam logic [7:0] ADDR_PTR_OFS  = 8'h00;  // byte pointer
    localparam logic [7:0] DATA_OFS      = 8'h04;  // data at pointer
    localparam logic [7:0] WIN_OFS       = 8'h08;  // aligned dword at ptr
    localparam logic [7:0] STAT_OFS      = 8'h0C;  // status / last access
    localparam logic [7:0] CTRL_OFS      = 8'h10;  // auto-increment control
    localparam logic [7:0] PTR_RST       = 8'h00;
    localparam int         CTRL_AUTOINC  = 0;
    localparam logic [7:0] UNMAPPED_BYTE = 8'hFF;

    // ******************************************************************
    // store contents
    // ******************************************************************
    localparam logic [7:0] VENDOR_ID     = 8'h5A;  // value is arbitrary
    localparam logic [7:0] ADR_SMAP_ID_L = 8'h10;
    localparam logic [7:0] ADR_SMAP_MIN  = 8'h11;
    localparam logic [7:0] ADR_SMAP_MAJ  = 8'h12;
    localparam logic [7:0] ADR_SMAP_LEN  = 8'h13;
    localparam logic [7:0] ADR_SMAP_P0   = 8'h14;
    localparam logic [7:0] ADR_SMAP_P1   = 8'h15;
    localparam logic [7:0] ADR_SMAP_P2   = 8'h16;
    localparam logic [7:0] ADR_SMAP_ID_H = 8'h17;
    localparam logic [7:0] ADR_VND_ID    = 8'h18;
    localparam logic [7:0] ADR_VND_MIN   = 8'h19;
    localparam logic [7:0] ADR_VND_MAJ   = 8'h1A;
    localparam logic [7:0] ADR_VND_LEN   = 8'h1B;
    localparam logic [7:0] ADR_VND_P0    = 8'h1C;
    localparam logic [7:0] ADR_VND_P1    = 8'h1D;
    localparam logic [7:0] ADR_VND_P2    = 8'h1E;
    localparam logic [7:0] ADR_VND_BANK  = 8'h1F;
    localparam logic [7:0] ADR_FPT_B0    = 8'h30;
    localparam logic [7:0] ADR_FPT_B1    = 8'h31;

    localparam logic [7:0] SMAP_ID_L     = 8'h81;
    localparam logic [7:0] SMAP_MIN      = 8'h00;
    localparam logic [7:0] SMAP_MAJ      = 8'h01;
    localparam logic [7:0] SMAP_LEN      = 8'h06;
    localparam logic [23:0] SMAP_TABLE_START_POINTER = 24'h000100;
    localparam logic [7:0] SMAP_ID_H     = 8'hFF;
    localparam logic [7:0] VND_MIN       = 8'h00;
    localparam logic [7:0] VND_MAJ       = 8'h01;
    localparam logic [7:0] VND_LEN       = 8'h18;
    localparam logic [23:0] VND_TABLE_START_POINTER  = 24'h000200;
    localparam logic [7:0] VND_BANK      = 8'h01;

    // first flash-parameter byte fields
    localparam logic [1:0] ERASE_4K_AVAIL = 2'b01;
    localparam logic       WR_GRAN_64     = 1'b1;
    localparam logic       STATUS_VOLAT   = 1'b1;
    localparam logic       WREN_SEL_06    = 1'b1;
    localparam logic [2:0] FPT_UNUSED     = 3'b111;
    localparam logic [7:0] ERASE_4K_OPC   = 8'h20;
    localparam logic [7:0] WREN_OPC_50    = 8'h50;
    localparam logic [7:0] WREN_OPC_06    = 8'h06;

    typedef struct packed {
        logic [2:0] unused;
        logic       wren_sel;
        logic       status_volatile;
        logic       write_gran;
        logic [1:0] erase_size;
    } fpt_byte0_t;

    localparam fpt_byte0_t FPT_BYTE0 = '{
        unused:          FPT_UNUSED,
        wren_sel:        WREN_SEL_06,
        status_volatile: STATUS_VOLAT,
        write_gran:      WR_GRAN_64,
        erase_size:      ERASE_4K_AVAIL
    };

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rom_rd_t;

endpackage

//--- rtl/sfdp_parameter_rom.sv
// fixed discoverable-parameter store with a classic wishbone slave
`timescale 1ns/1ps

// Behaviour
// - byte 13H returns 06H, sector-map table length in dwords
// - bytes 14H-16H return 00H 01H 00H, sector-map table pointer
// - byte 17H returns FFH, sector-map identifier high byte
// - byte 18H returns the vendor identification code
// - bytes 19H and 1AH return 00H and 01H, vendor table revision
// - byte 1BH returns 18H, vendor table length in dwords
// - bytes 1CH-1EH return 00H 02H 00H, vendor table pointer
// - byte 1FH returns 01H, vendor bank number indicator
// - byte 30H returns FDH; low bits 01 mean 4 KByte erase available
// - byte 30H bit 2 set: program buffer of at least 64 bytes
// - byte 30H bit 3 set: status bits are volatile
// - byte 30H bit 4 set: host uses 06H write enable, else 50H
// - byte 30H bits 7 to 5 always read 111b
// - byte 31H returns 20H, the 4 KByte erase opcode
// - bytes 10H-12H return 81H, 00H and 01H
module sfdp_parameter_rom
    import param_rom_pkg::*;
(
    input  wire logic        clk_i,       // 100 MHz system clock
    input  wire logic        rst_i,       // synchronous reset, active high
    input  wire logic        wb_cyc_i,    // bus cycle
    input  wire logic        wb_stb_i,    // strobe
    input  wire logic        wb_we_i,     // write enable
    input  wire logic [7:0]  wb_adr_i,    // byte address
    input  wire logic [3:0]  wb_sel_i,    // byte enables
    input  wire logic [31:0] wb_dat_i,    // write data
    output logic      [31:0] wb_dat_o,    // read data, registered
    output logic             wb_ack_o,    // acknowledge
    output logic      [7:0]  wren_opc_o   // write-enable opcode host must use
);

    // ******************************************************************
    // content lookup
    // ******************************************************************
    // the table is a pure function of address; nothing stores it, so no
    // program, erase or status write can ever alter what reads return
    function automatic rom_rd_t rom_lookup(input logic [7:0] a);
        rom_rd_t r;
        r.valid = 1'b1;
        r.data  = UNMAPPED_BYTE;
        case (a)
            // sector-map header, identifier low byte
            ADR_SMAP_ID_L: begin
                r.data = SMAP_ID_L;
            end

            // sector-map header, minor revision
            ADR_SMAP_MIN: begin
                r.data = SMAP_MIN;
            end

            // sector-map header, major revision
            ADR_SMAP_MAJ: begin
                r.data = SMAP_MAJ;
            end

            // sector-map table length in dwords
            ADR_SMAP_LEN: begin
                r.data = SMAP_LEN;
            end

            // sector-map table start, least significant byte first
            ADR_SMAP_P0: begin
                r.data = SMAP_TABLE_START_POINTER[7:0];
            end

            ADR_SMAP_P1: begin
                r.data = SMAP_TABLE_START_POINTER[15:8];
            end

            ADR_SMAP_P2: begin
                r.data = SMAP_TABLE_START_POINTER[23:16];
            end

            // sector-map identifier high byte
            ADR_SMAP_ID_H: begin
                r.data = SMAP_ID_H;
            end

            // vendor header: maker code marks it vendor-specified
            ADR_VND_ID: begin
                r.data = VENDOR_ID;
            end

            // vendor table revision, minor then major
            ADR_VND_MIN: begin
                r.data = VND_MIN;
            end

            ADR_VND_MAJ: begin
                r.data = VND_MAJ;
            end

            // vendor table length in dwords
            ADR_VND_LEN: begin
                r.data = VND_LEN;
            end

            // vendor table start, least significant byte first
            ADR_VND_P0: begin
                r.data = VND_TABLE_START_POINTER[7:0];
            end

            ADR_VND_P1: begin
                r.data = VND_TABLE_START_POINTER[15:8];
            end

            ADR_VND_P2: begin
                r.data = VND_TABLE_START_POINTER[23:16];
            end

            // vendor bank number indicator
            ADR_VND_BANK: begin
                r.data = VND_BANK;
            end

            // erase size, write granularity, status kind, opcode select
            ADR_FPT_B0: begin
                r.data = FPT_BYTE0;
            end

            // opcode the host sends for a 4 KByte erase
            ADR_FPT_B1: begin
                r.data = ERASE_4K_OPC;
            end

            // outside this table: bytes read as erased
            default: begin
                r.valid = 1'b0;
            end
        endcase
        return r;
    endfunction

    // opcode the host must send before a volatile status write; while the
    // status bits are nonvolatile the select bit means nothing
    function automatic logic [7:0] wren_pick(input fpt_byte0_t b);
        logic [7:0] o;
        o = WREN_OPC_50;
        case ({b.status_volatile, b.wren_sel})
            2'h3: begin
                o = WREN_OPC_06;
            end

            2'h2: begin
                o = WREN_OPC_50;
            end

            default: begin
                o = WREN_OPC_50;
            end
        endcase
        return o;
    endfunction

    // ******************************************************************
    // bus slave state
    // ******************************************************************
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       autoinc_q;
    logic       last_miss_q;
    logic       ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic       req;
    logic       wr_ptr;
    logic       rd_data;
    rom_rd_t    cur;
    rom_rd_t    win [4];
    logic [7:0] win_base;

    // ******************************************************************
    // register write decode
    // ******************************************************************
    // a fresh write aimed at one offset with the low lane enabled; the
    // upper lanes carry nothing for any register of this block
    function automatic logic reg_wr(input logic [7:0] ofs);
        return req && wb_we_i && (wb_adr_i == ofs) && wb_sel_i[0];
    endfunction

    // single-cycle answer; ack drops the cycle after it was given
    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_ptr   = reg_wr(ADDR_PTR_OFS);
    assign rd_data  = req && !wb_we_i && wb_adr_i == DATA_OFS;
    assign cur      = rom_lookup(ptr_q);
    assign win_base = {ptr_q[7:2], 2'b00};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_win
            assign win[g] = rom_lookup(win_base | 8'(g));
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // ******************************************************************
    // pointer and control
    // ******************************************************************
    always_comb begin
        ptr_d = ptr_q;
        if (wr_ptr) begin
            ptr_d = wb_dat_i[7:0];
        end else if (rd_data && autoinc_q) begin
            ptr_d = ptr_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q <= PTR_RST;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            autoinc_q <= 1'b0;
        end else if (reg_wr(CTRL_OFS)) begin
            autoinc_q <= wb_dat_i[CTRL_AUTOINC];
        end
    end

    // sticky miss flag: a new miss wins over the clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_miss_q <= 1'b0;
        end else if (rd_data && !cur.valid) begin
            last_miss_q <= 1'b1;
        end else if (reg_wr(STAT_OFS)) begin
            last_miss_q <= 1'b0;
        end
    end

    // ******************************************************************
    // read data
    // ******************************************************************
    // writes to data/window offsets are ignored: the store is read-only
    always_comb begin
        rdat_d = 32'h0000_0000;
        case (wb_adr_i)
            // pointer read back
            ADDR_PTR_OFS: begin
                rdat_d = {24'h00_0000, ptr_q};
            end

            // byte at the pointer in the low lane
            DATA_OFS: begin
                rdat_d = {24'h00_0000, cur.data};
            end

            // aligned dword holding the pointer, lowest byte in lane 0
            WIN_OFS: begin
                rdat_d = {win[3].data,
                          win[2].data,
                          win[1].data,
                          win[0].data};
            end

            // sticky miss and validity of the current pointer
            STAT_OFS: begin
                rdat_d = {30'h0000_0000, last_miss_q, cur.valid};
            end

            CTRL_OFS: begin
                rdat_d = {31'h0000_0000, autoinc_q};
            end

            // unmapped offsets read zero
            default: begin
                rdat_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdat_q <= rdat_d;
        end
    end

    // host picks its volatile-status write-enable opcode from this bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wren_opc_o <= WREN_OPC_50;
        end else begin
            wren_opc_o <= wren_pick(FPT_BYTE0);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

endmodule

//--- tb/sfdp_parameter_rom_assertions.sv
// concurrent checks on the parameter store bus ports
`timescale 1ns/1ps
module rom_checker
    import param_rom_pkg::*;
(
    input wire logic        clk_i,      // clock
    input wire logic        rst_i,      // reset
    input wire logic        wb_cyc_i,   // cycle
    input wire logic        wb_stb_i,   // strobe
    input wire logic        wb_we_i,    // write
    input wire logic [7:0]  wb_adr_i,   // address
    input wire logic [3:0]  wb_sel_i,   // byte enables
    input wire logic [31:0] wb_dat_i,   // write data
    input wire logic [31:0] wb_dat_o,   // read data
    input wire logic        wb_ack_o,   // acknowledge
    input wire logic [7:0]  wren_opc_o  // opcode
);
    // pointer shadow, so a data read can be tied to the byte it targets
    logic [7:0] ptr_q;
    logic       inc_q;
    logic       take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q <= 8'h00;
            inc_q <= 1'b0;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == ADDR_PTR_OFS) ptr_q <= wb_dat_i[7:0];
            if (wb_adr_i == CTRL_OFS) inc_q <= wb_dat_i[0];
        end else if (take && !wb_we_i && wb_adr_i == DATA_OFS && inc_q) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd(a);
        take && !wb_we_i && wb_adr_i == a;
    endsequence
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ack_lat; take |=> wb_ack_o; endproperty
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_wren;
        !$past(rst_i) && !$past(rst_i, 2) |-> wren_opc_o == WREN_OPC_06;
    endproperty
    property p_b30; s_rd(DATA_OFS) ##0 ptr_q == 8'h30 |=> wb_dat_o[7:0] == 8'hFD;
    endproperty
    property p_b31; s_rd(DATA_OFS) ##0 ptr_q == 8'h31 |=> wb_dat_o[7:0] == 8'h20;
    endproperty
    property p_unmap; s_rd(8'h40) |=> wb_dat_o == 32'h0; endproperty
    property p_wr_hold; take && wb_we_i |=> $stable(wb_dat_o); endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    a_wren: assert property (p_wren) else $error("bad opcode");
    a_b30: assert property (p_b30) else $error("byte 30 bad");
    a_b31: assert property (p_b31) else $error("byte 31 bad");
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    a_wr_hold: assert property (p_wr_hold) else $error("write moved data");
endmodule
bind sfdp_parameter_rom rom_checker rom_checker_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wren_opc_o(wren_opc_o));

//--- tb/wb_host_model.sv
// host controller model issuing classic bus cycles
`timescale 1ns/1ps
module wb_host_model (
    input  wire logic        clk_i,  // clock
    input  wire logic [31:0] rdat_i, // read data
    input  wire logic        ack_i,  // acknowledge
    output logic             cyc_o,  // cycle
    output logic             stb_o,  // strobe
    output logic             we_o,   // write
    output logic [7:0]       adr_o,  // address
    output logic [3:0]       sel_o,  // byte enables
    output logic [31:0]      dat_o   // write data
);
    logic tmo = 1'b0;
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    // released address and data lines are inverted so a stale value never passes
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hF, wd};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack_i === 1'b1) break;
        end
        tmo = (n == 20);
        rd = rdat_i;
        {cyc_o, stb_o, adr_o, dat_o} <= {2'b00, ~a, ~wd};
    endtask
endmodule

//--- tb/sfdp_parameter_rom_test.sv
// self-checking bench for the parameter store
`timescale 1ns/1ps
module sfdp_parameter_rom_test;
    import param_rom_pkg::*;
    localparam logic [7:0] HDR [16] = '{8'h81, 8'h00, 8'h01, 8'h06,
        8'h00, 8'h01, 8'h00, 8'hFF, VENDOR_ID, 8'h00, 8'h01, 8'h18,
        8'h00, 8'h02, 8'h00, 8'h01};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack;
    logic [7:0]  adr, opc;
    logic [3:0]  sel;
    logic [31:0] wd, rdat;
    int          fail_count = 0;
    int          checked = 0;
    always #5 clk_i = ~clk_i;
    sfdp_parameter_rom sfdp_parameter_rom_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wren_opc_o(opc));
    wb_host_model wb_host_model_i (.clk_i(clk_i), .rdat_i(rdat),
        .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wd));
    function automatic logic [7:0] exp_b(input logic [7:0] a);
        if (a inside {[8'h10:8'h1F]}) return HDR[a[3:0]];
        if (a == 8'h30) return 8'hFD;
        if (a == 8'h31) return 8'h20;
        return 8'hFF;
    endfunction
    task automatic print_verdict;
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        wb_host_model_i.xfer(w, a, d, r);
        if (wb_host_model_i.tmo) begin
            fail_count++;
            $display("[FAIL] %0t no ack", $time);
            print_verdict();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (logic [7:0] a = 8'h10; a < 8'h32; a++) begin
            wr(ADDR_PTR_OFS, {24'h0, a});
            rd_chk(DATA_OFS, 32'hFF, {24'h0, exp_b(a)});
        end
        // unaligned pointer: the window must still align down
        for (logic [7:0] a = 8'h10; a < 8'h34; a += 8'h04) begin
            wr(ADDR_PTR_OFS, {24'h0, a + 8'h01});
            rd_chk(WIN_OFS, 32'hFFFFFFFF, {exp_b(a + 8'h03), exp_b(a + 8'h02),
                exp_b(a + 8'h01), exp_b(a)});
        end
        wr(CTRL_OFS, 32'h1);
        wr(ADDR_PTR_OFS, 32'h10);
        for (int i = 0; i < 16; i++) begin
            rd_chk(DATA_OFS, 32'hFF, {24'h0, HDR[i]});
        end
        wr(CTRL_OFS, 32'h0);
        wr(DATA_OFS, 32'h0);
        wr(WIN_OFS, 32'h0);
        wr(8'h40, 32'h0);
        wr(ADDR_PTR_OFS, 32'h30);
        rd_chk(WIN_OFS, 32'hFFFFFFFF, 32'hFFFF20FD);
        rd_chk(DATA_OFS, 32'hFF, 32'hFD);
        rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
        wr(ADDR_PTR_OFS, 32'h40);
        rd_chk(DATA_OFS, 32'hFF, 32'hFF);
        rd_chk(STAT_OFS, 32'h3, 32'h2);
        wr(STAT_OFS, 32'h0);
        rd_chk(STAT_OFS, 32'h3, 32'h0);
        chk({24'h0, opc}, 32'h06);
        print_verdict();
    end
endmodule
